//--- src/tcap_map.svh
// Notes on behaviour
// [RULE1] Sixteen channels, each samples one assigned parameter.
// [RULE2] Buffer holds exactly 100 samples per channel.
// [RULE3] Trigger uses only channel one's value.
// [RULE4] Unassigned channels inactive; any subset works.
// [RULE5] Sample interval programmable up to 20000 ms.
// [RULE6] Post-trigger share 0 to 100 percent.
// [RULE7] Mode selects single-shot or continuous, reported S/C.
// [RULE8] Single-shot triggers once, then stops capturing.
// [RULE9] Terminal must restart after single-shot capture.
// [RULE10] Restart clears buffer before new capture.
// [RULE11] Continuous rearms itself until data read stops it.
// [RULE12] Selectable condition codes including equal and OR.
// [RULE13] Programmed trigger data is the comparison operand.
// [RULE14] Interval zero means one sample per millisecond.
// [RULE15] Circular pre-trigger writes, freeze after post count.
// [RULE16] Boolean conditions bitwise; nonzero result triggers.
`ifndef TCAP_MAP_SVH
`define TCAP_MAP_SVH
`define TCAP_NUM_CH       16
`define TCAP_CH_W         16
`define TCAP_DEPTH        7'h64
`define TCAP_RATE_MAX     15'h4e20
`define TCAP_POST_MAX     7'h64
`define TCAP_CLK_NS       10
`define TCAP_MS_NS        1000000
`define TCAP_CYC_PER_MS   (`TCAP_MS_NS / `TCAP_CLK_NS)
`define TCAP_OFS_CTRL     8'h00
`define TCAP_OFS_TDATA    8'h04
`define TCAP_OFS_RATE     8'h08
`define TCAP_OFS_POST     8'h0c
`define TCAP_OFS_CHEN     8'h10
`define TCAP_OFS_RESTART  8'h14
`define TCAP_OFS_STATUS   8'h18
`define TCAP_OFS_ISTAT    8'h1c
`define TCAP_OFS_IMASK    8'h20
`define TCAP_OFS_RDIDX    8'h24
`define TCAP_OFS_RDATA    8'h28
`define TCAP_CTRL_MODE    0
`define TCAP_CTRL_COND_LO 1
`define TCAP_CTRL_COND_HI 3
`define TCAP_RDIDX_CH_LO  8
`define TCAP_IRQ_TRIG     0
`define TCAP_IRQ_DONE     1
`define TCAP_IND_S        8'h53
`define TCAP_IND_C        8'h43
`endif

//--- src/tcap_pkg.sv
`default_nettype none
package tcap_pkg;
  // Trigger condition codes, in register encoding order.
  typedef enum logic [2:0] {
    tcap_eq, tcap_ne, tcap_gt, tcap_lt, tcap_or, tcap_nor, tcap_and, tcap_nand
  } tcap_cond_e;
  // Capture sequencer states.
  typedef enum logic [1:0] {st_stop, st_armed, st_post, st_done} tcap_state_e;
endpackage
`default_nettype wire

//--- src/tcap_tick.sv
`include "tcap_map.svh"
`default_nettype none
module tcap_tick #(
  parameter int CYC_PER_MS = `TCAP_CYC_PER_MS
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        run,
  input  wire logic [14:0] rate,
  output logic             sample_tick
);
  logic [16:0] cyc;
  logic [14:0] ms;
  logic [16:0] next_cyc;
  logic [14:0] next_ms;
  logic        ms_tick;
  logic [14:0] ms_last;

  // Millisecond enable, then interval count; zero interval samples every millisecond.
  always_comb begin
    ms_tick  = (cyc == 17'(CYC_PER_MS - 1));
    ms_last  = (rate == 15'h0) ? 15'h0 : rate - 15'h1; // see [RULE14]
    next_cyc = ms_tick ? 17'h0 : cyc + 17'h1;
    next_ms  = ms;
    if (ms_tick) begin
      next_ms = (ms >= ms_last) ? 15'h0 : ms + 15'h1; // see [RULE5]
    end
    if (!run) begin
      next_cyc = 17'h0;
      next_ms  = 15'h0;
    end
    sample_tick = run && ms_tick && (ms >= ms_last);
  end

  // Counter registers.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc <= 17'h0;
      ms  <= 15'h0;
    end else begin
      cyc <= next_cyc;
      ms  <= next_ms;
    end
  end
endmodule // tcap_tick
`default_nettype wire

//--- src/tcap_cmp.sv
`default_nettype none
module tcap_cmp (
  input  wire logic                    [15:0] value,
  input  wire logic                    [15:0] data,
  input  wire tcap_pkg::tcap_cond_e           cond,
  output logic                                hit
);
  // Compares channel one against the trigger data; Boolean codes fire on a nonzero result.
  always_comb begin
    case (cond)
      tcap_pkg::tcap_eq:   hit = (value == data); // see [RULE12]
      tcap_pkg::tcap_ne:   hit = (value != data);
      tcap_pkg::tcap_gt:   hit = (value > data);
      tcap_pkg::tcap_lt:   hit = (value < data);
      tcap_pkg::tcap_or:   hit = |(value | data); // see [RULE16]
      tcap_pkg::tcap_nor:  hit = |(~(value | data));
      tcap_pkg::tcap_and:  hit = |(value & data);
      tcap_pkg::tcap_nand: hit = |(~(value & data));
      default:             hit = 1'b0;
    endcase
  end
endmodule // tcap_cmp
`default_nettype wire

//--- src/tcap_top.sv
// Added by the designer: the address map and the APB interface to the registers.
`include "tcap_map.svh"
`default_nettype none
module tcap_top #(
  parameter int CYC_PER_MS = `TCAP_CYC_PER_MS
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic [255:0] param_values,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic              pready,
  output logic              pslverr,
  output logic [31:0]       prdata,
  output logic              irq
);
  ////////////////////////////////////////////////////////////////////////////
  // Declarations.
  tcap_pkg::tcap_state_e state, next_state;
  tcap_pkg::tcap_cond_e  cond, next_cond;
  logic         mode_cont, next_mode_cont;
  logic [15:0]  trig_data, next_trig_data;
  logic [14:0]  rate, next_rate;
  logic [6:0]   post, next_post;
  logic [15:0]  chan_en, next_chan_en;
  logic [1:0]   irq_stat, next_irq_stat;
  logic [1:0]   irq_mask, next_irq_mask;
  logic [6:0]   rd_idx, next_rd_idx;
  logic [3:0]   rd_ch, next_rd_ch;
  logic [6:0]   wr_ptr, next_wr_ptr;
  logic [6:0]   fill, next_fill;
  logic [6:0]   post_cnt, next_post_cnt;
  logic [6:0]   post_goal, next_post_goal;
  logic [31:0]  next_prdata;
  logic [255:0] mem [0:99];
  logic [255:0] sample_word;
  logic         acc, wr, rd, mapped, capture_restart, rdata_read, istat_read;
  logic         tick, hit, run, mem_we, ev_trig, ev_done;
  logic [7:0]   phys_sum;
  logic [6:0]   phys;
  logic [255:0] rd_word;
  logic [15:0]  rd_val;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode; every access completes without wait states.
  assign pready = 1'b1;
  assign acc    = psel && penable;
  assign wr     = acc && pwrite;
  assign rd     = acc && !pwrite;
  assign mapped = (paddr <= `TCAP_OFS_RDATA) && (paddr[1:0] == 2'h0);
  assign pslverr         = acc && !mapped;
  assign capture_restart = wr && (paddr == `TCAP_OFS_RESTART);
  assign rdata_read      = rd && (paddr == `TCAP_OFS_RDATA);
  assign istat_read      = rd && (paddr == `TCAP_OFS_ISTAT);
  assign irq             = |(irq_stat & irq_mask);

  ////////////////////////////////////////////////////////////////////////////
  // Sample pacing and trigger comparison.
  assign run = (state == tcap_pkg::st_armed) || (state == tcap_pkg::st_post);

  tcap_tick #(
    .CYC_PER_MS (CYC_PER_MS)
  ) u_tick (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .run         (run),
    .rate        (rate),
    .sample_tick (tick)
  );

  // Only channel one feeds the comparator, against the programmed data.
  tcap_cmp u_cmp (
    .value (param_values[15:0]), // see [RULE3]
    .data  (trig_data), // see [RULE13]
    .cond  (cond),
    .hit   (hit)
  );

  // Unassigned channels are stored as zero so any subset captures cleanly.
  genvar g;
  generate
    for (g = 0; g < `TCAP_NUM_CH; g++) begin : g_mask
      assign sample_word[g*16 +: 16] = chan_en[g] ? param_values[g*16 +: 16] : 16'h0; // see [RULE1] [RULE4]
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers written by software.
  always_comb begin
    next_mode_cont = mode_cont;
    next_cond      = cond;
    next_trig_data = trig_data;
    next_rate      = rate;
    next_post      = post;
    next_chan_en   = chan_en;
    next_irq_mask  = irq_mask;
    next_rd_idx    = rd_idx;
    next_rd_ch     = rd_ch;
    if (wr) begin
      case (paddr)
        `TCAP_OFS_CTRL: begin
          next_mode_cont = pwdata[`TCAP_CTRL_MODE]; // see [RULE7]
          next_cond      = tcap_pkg::tcap_cond_e'(pwdata[`TCAP_CTRL_COND_HI:`TCAP_CTRL_COND_LO]); // see [RULE12]
        end
        `TCAP_OFS_TDATA: next_trig_data = pwdata[15:0];
        `TCAP_OFS_RATE: begin
          next_rate = (pwdata[31:0] > 32'(`TCAP_RATE_MAX)) ? `TCAP_RATE_MAX : pwdata[14:0]; // see [RULE5]
        end
        `TCAP_OFS_POST: begin
          next_post = (pwdata[31:0] > 32'(`TCAP_POST_MAX)) ? `TCAP_POST_MAX : pwdata[6:0]; // see [RULE6]
        end
        `TCAP_OFS_CHEN:  next_chan_en = pwdata[15:0];
        `TCAP_OFS_IMASK: next_irq_mask = pwdata[1:0];
        `TCAP_OFS_RDIDX: begin
          next_rd_idx = (pwdata[6:0] >= `TCAP_DEPTH) ? `TCAP_DEPTH - 7'h1 : pwdata[6:0];
          next_rd_ch  = pwdata[`TCAP_RDIDX_CH_LO +: 4];
        end
        default: next_rd_ch = rd_ch;
      endcase
    end
  end

  // Configuration register bank.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_cont <= 1'b0;
      cond      <= tcap_pkg::tcap_eq;
      trig_data <= 16'h0;
      rate      <= 15'h0;
      post      <= 7'h0;
      chan_en   <= 16'h0;
      irq_mask  <= 2'h0;
      rd_idx    <= 7'h0;
      rd_ch     <= 4'h0;
    end else begin
      mode_cont <= next_mode_cont;
      cond      <= next_cond;
      trig_data <= next_trig_data;
      rate      <= next_rate;
      post      <= next_post;
      chan_en   <= next_chan_en;
      irq_mask  <= next_irq_mask;
      rd_idx    <= next_rd_idx;
      rd_ch     <= next_rd_ch;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture sequencer: circular pre-trigger fill, counted post-trigger fill.
  always_comb begin
    next_state    = state;
    next_wr_ptr   = wr_ptr;
    next_fill     = fill;
    next_post_cnt = post_cnt;
    next_post_goal = post_goal;
    mem_we        = 1'b0;
    ev_trig       = 1'b0;
    ev_done       = 1'b0;
    if (run && tick) begin
      mem_we      = 1'b1;
      next_wr_ptr = (wr_ptr == `TCAP_DEPTH - 7'h1) ? 7'h0 : wr_ptr + 7'h1; // see [RULE15]
      next_fill   = (fill == `TCAP_DEPTH) ? fill : fill + 7'h1; // see [RULE2]
    end
    case (state)
      tcap_pkg::st_armed: begin
        if (tick && hit) begin
          ev_trig       = 1'b1;
          next_post_cnt = 7'h0;
          next_post_goal = post; // The share is frozen at the trigger so later writes cannot overrun it.
          if (post == 7'h0) begin
            ev_done    = 1'b1;
            next_state = tcap_pkg::st_done;
          end else begin
            next_state = tcap_pkg::st_post;
          end
        end
      end
      tcap_pkg::st_post: begin
        if (tick) begin
          next_post_cnt = post_cnt + 7'h1;
          if (post_cnt + 7'h1 >= post_goal) begin
            ev_done    = 1'b1;
            next_state = tcap_pkg::st_done; // see [RULE6] [RULE15]
          end
        end
      end
      tcap_pkg::st_done:  next_state = state; // see [RULE8]
      tcap_pkg::st_stop:  next_state = state;
      default:            next_state = tcap_pkg::st_stop;
    endcase
    // Continuous mode throws the finished trend away and arms again at once.
    if (ev_done && mode_cont) begin
      next_state  = tcap_pkg::st_armed; // see [RULE11]
      next_wr_ptr = 7'h0;
      next_fill   = 7'h0;
    end
    // Reading captured data halts a running continuous capture.
    if (rdata_read && mode_cont && run) begin
      next_state = tcap_pkg::st_stop; // see [RULE11]
      mem_we     = 1'b0;
      next_wr_ptr = wr_ptr;
      next_fill   = fill;
    end
    // Restart empties the buffer and arms from any state.
    if (capture_restart) begin
      next_state    = tcap_pkg::st_armed; // see [RULE9] [RULE10]
      next_wr_ptr   = 7'h0;
      next_fill     = 7'h0;
      next_post_cnt = 7'h0;
      mem_we        = 1'b0;
    end
  end

  // Sequencer registers.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= tcap_pkg::st_stop;
      wr_ptr   <= 7'h0;
      fill     <= 7'h0;
      post_cnt <= 7'h0;
      post_goal <= 7'h0;
    end else begin
      state    <= next_state;
      wr_ptr   <= next_wr_ptr;
      fill     <= next_fill;
      post_cnt <= next_post_cnt;
      post_goal <= next_post_goal;
    end
  end

  // Sample store; one word carries all sixteen channels of one sample.
  always_ff @(posedge sys_clk) begin
    if (mem_we) begin
      mem[wr_ptr] <= sample_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status: set wins over the clearing read.
  always_comb begin
    next_irq_stat = istat_read ? 2'h0 : irq_stat;
    if (ev_trig) begin
      next_irq_stat[`TCAP_IRQ_TRIG] = 1'b1;
    end
    if (ev_done) begin
      next_irq_stat[`TCAP_IRQ_DONE] = 1'b1;
    end
  end

  // Interrupt status register.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat <= 2'h0;
    end else begin
      irq_stat <= next_irq_stat;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path: index 0 is the oldest held sample; unfilled slots read zero.
  always_comb begin
    phys_sum = {1'b0, wr_ptr} + {1'b0, rd_idx};
    if (fill != `TCAP_DEPTH) begin
      phys = rd_idx;
    end else if (phys_sum >= {1'b0, `TCAP_DEPTH}) begin
      phys = 7'(phys_sum - {1'b0, `TCAP_DEPTH});
    end else begin
      phys = phys_sum[6:0];
    end
    rd_word = mem[phys];
    rd_val  = (rd_idx < fill) ? rd_word[rd_ch*16 +: 16] : 16'h0; // see [RULE10]
    next_prdata = 32'h0;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        `TCAP_OFS_CTRL:   next_prdata = {28'h0, cond, mode_cont};
        `TCAP_OFS_TDATA:  next_prdata = {16'h0, trig_data};
        `TCAP_OFS_RATE:   next_prdata = {17'h0, rate};
        `TCAP_OFS_POST:   next_prdata = {25'h0, post};
        `TCAP_OFS_CHEN:   next_prdata = {16'h0, chan_en};
        `TCAP_OFS_STATUS: next_prdata = {8'h0, mode_cont ? `TCAP_IND_C : `TCAP_IND_S, 1'b0, fill, 6'h0, state}; // see [RULE7]
        `TCAP_OFS_ISTAT:  next_prdata = {30'h0, irq_stat};
        `TCAP_OFS_IMASK:  next_prdata = {30'h0, irq_mask};
        `TCAP_OFS_RDIDX:  next_prdata = {20'h0, rd_ch, 1'b0, rd_idx};
        `TCAP_OFS_RDATA:  next_prdata = {16'h0, rd_val};
        default:          next_prdata = 32'h0;
      endcase
    end else begin
      next_prdata = prdata;
    end
  end

  // Read data is captured in the setup cycle and held through the access.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0;
    end else begin
      prdata <= next_prdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  sequence s_restart;
    capture_restart;
  endsequence
  sequence s_armed_empty;
    state == tcap_pkg::st_armed && fill == 7'h0;
  endsequence

  a_restart_clears: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [RULE10]
    s_restart |=> s_armed_empty) else $error("restart did not clear and arm");
  a_single_stops: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [RULE8]
    (state == tcap_pkg::st_done && !capture_restart) |=> state == tcap_pkg::st_done)
    else $error("single-shot left done without restart");
  a_cont_rearms: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [RULE11]
    (ev_done && mode_cont && !capture_restart && !rdata_read) |=> s_armed_empty)
    else $error("continuous capture did not rearm");
  a_post_count: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [RULE6]
    (state == tcap_pkg::st_post) |-> post_cnt < post_goal) else $error("post count overran");
  a_fill_bound: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [RULE2]
    fill <= `TCAP_DEPTH && wr_ptr < `TCAP_DEPTH) else $error("buffer index out of range");
  a_trig_ch1: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [RULE3]
    ev_trig |-> state == tcap_pkg::st_armed && hit && tick) else $error("trigger without channel one hit");
  a_ind_mode: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [RULE7]
    (psel && !penable && !pwrite && paddr == `TCAP_OFS_STATUS) |=>
      prdata[23:16] == (mode_cont ? `TCAP_IND_C : `TCAP_IND_S)) else $error("wrong mode indicator");
  a_inactive_zero: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [RULE4]
    mem_we |-> (sample_word[15:0] == 16'h0) || chan_en[0]) else $error("inactive channel stored data");
  a_irq_level: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ev_done |=> irq_stat[`TCAP_IRQ_DONE] ##0 (irq == |(irq_stat & irq_mask)))
    else $error("done event lost");
  a_rate_max: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [RULE5]
    rate <= `TCAP_RATE_MAX && post <= `TCAP_POST_MAX) else $error("setting above maximum");
endmodule // tcap_top
`default_nettype wire

//--- tb/tcap_term.sv
`include "tcap_map.svh"
`default_nettype none
module tcap_term (
  input  wire logic        sys_clk,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata
);
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////////
  // The terminal leaves the bus idle until it has something to ask.
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One bus transfer: setup, then access held until pready is sampled high.
  // Address and data are inverted on release so that no stale value looks valid.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1)
      @(posedge sys_clk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~d;
    @(posedge sys_clk);
  endtask

  // A finished single-shot capture is only rearmed by this explicit command.
  task automatic restart();
    logic [31:0] q;
    logic        e;
    xfer(1'b1, `TCAP_OFS_RESTART, 32'h0000_0001, q, e);
  endtask
endmodule // tcap_term
`default_nettype wire

//--- tb/tcap_top_bench.sv
`include "tcap_map.svh"
`default_nettype none
module tcap_top_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic         sys_clk;
  logic         rst_n;
  logic [255:0] param_values;
  logic         psel;
  logic         penable;
  logic         pwrite;
  logic [7:0]   paddr;
  logic [31:0]  pwdata;
  logic         pready;
  logic         pslverr;
  logic [31:0]  prdata;
  logic         irq;
  int           errors;
  int           checks;

  ////////////////////////////////////////////////////////////////////////////////
  // Design with a four-cycle millisecond, so that at interval zero a sample comes every four cycles.
  tcap_top #(.CYC_PER_MS(4)) dut_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .param_values(param_values), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .irq(irq));

  // Operator terminal model that owns the register bus.
  tcap_term term_u (
    .sys_clk(sys_clk), .pready(pready), .pslverr(pslverr), .prdata(prdata), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  // Clock of 10 ns period.
  always #5 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////////////
  // Ends the run with the verdict.
  task automatic finish_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Compares a seen value against the expected one.
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    term_u.xfer(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    term_u.xfer(1'b0, a, 32'h0000_0000, q, e);
  endtask

  // Reads a register and compares it in one step.
  task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    rd(a, q);
    chk(name, q, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Reset state, the refused addresses and the interval and share clamps.
  task automatic t_reset_map();
    logic [31:0] q;
    logic        e;
    chk("irq_reset", {31'h0, irq}, 32'h0);
    chk("pready", {31'h0, pready}, 32'h1);
    rdchk("status_reset", `TCAP_OFS_STATUS, 32'h0053_0000);
    term_u.xfer(1'b0, 8'h30, 32'h0, q, e);
    chk("unmapped_err", {31'h0, e}, 32'h1);
    chk("unmapped_data", q, 32'h0);
    term_u.xfer(1'b0, 8'h02, 32'h0, q, e);
    chk("unaligned_err", {31'h0, e}, 32'h1);
    wr(`TCAP_OFS_RATE, 32'h0000_7530);
    rdchk("rate_clamp", `TCAP_OFS_RATE, 32'h0000_4e20);
    wr(`TCAP_OFS_POST, 32'h0000_0078);
    rdchk("post_clamp", `TCAP_OFS_POST, 32'h0000_0064);
  endtask

  // A rate of two gives one sample every two milliseconds.
  task automatic t_rate();
    logic [31:0] q;
    param_values <= 256'h0;
    wr(`TCAP_OFS_CTRL, 32'h0);
    wr(`TCAP_OFS_TDATA, 32'h8);
    wr(`TCAP_OFS_RATE, 32'h2);
    term_u.restart();
    cyc(36);
    rd(`TCAP_OFS_STATUS, q);
    chk("fill_rate_a", {25'h0, q[14:8]}, 32'h4);
    cyc(2);
    rd(`TCAP_OFS_STATUS, q);
    chk("fill_rate_b", {25'h0, q[14:8]}, 32'h5);
  endtask

  // Single shot with ten percent after the trigger and two active channels.
  task automatic t_single();
    param_values <= {16'h2222, 16'h1111, 16'h0000} | 256'h0;
    wr(`TCAP_OFS_RATE, 32'h0);
    wr(`TCAP_OFS_POST, 32'd10);
    wr(`TCAP_OFS_CHEN, 32'h0003);
    wr(`TCAP_OFS_IMASK, 32'h2);
    term_u.restart();
    cyc(600);
    rdchk("status_full", `TCAP_OFS_STATUS, 32'h0053_6401);
    param_values[15:0] <= 16'h0008;
    cyc(100);
    rdchk("status_done", `TCAP_OFS_STATUS, 32'h0053_6403);
    chk("irq_done", {31'h0, irq}, 32'h1);
    wr(`TCAP_OFS_RDIDX, 32'd88);
    rdchk("pre_last", `TCAP_OFS_RDATA, 32'h0);
    wr(`TCAP_OFS_RDIDX, 32'd89);
    rdchk("trig_sample", `TCAP_OFS_RDATA, 32'h8);
    wr(`TCAP_OFS_RDIDX, 32'd99);
    rdchk("post_last", `TCAP_OFS_RDATA, 32'h8);
    wr(`TCAP_OFS_RDIDX, 32'h0000_0200);
    rdchk("inactive_ch", `TCAP_OFS_RDATA, 32'h0);
    wr(`TCAP_OFS_RDIDX, 32'h0000_0100);
    rdchk("active_ch", `TCAP_OFS_RDATA, 32'h1111);
    rdchk("istat", `TCAP_OFS_ISTAT, 32'h3);
    rdchk("istat_clr", `TCAP_OFS_ISTAT, 32'h0);
    chk("irq_clr", {31'h0, irq}, 32'h0);
    param_values[15:0] <= 16'h0000;
    cyc(20);
    param_values[15:0] <= 16'h0008;
    cyc(20);
    rdchk("no_retrigger", `TCAP_OFS_STATUS, 32'h0053_6403);
    term_u.restart();
    rdchk("cleared", `TCAP_OFS_RDATA, 32'h0);
  endtask

  // Every condition code, once firing and once holding off, with post share zero.
  task automatic t_cond();
    logic [31:0] hp [8] = '{32'h0005_0005, 32'h0005_0003, 32'h0005_0003, 32'h0003_0005,
                            32'h0004_0001, 32'h0000_0000, 32'h0005_0004, 32'h0005_0002};
    logic [31:0] mp [8] = '{32'h0005_0003, 32'h0005_0005, 32'h0003_0005, 32'h0005_0003,
                            32'h0000_0000, 32'hffff_0000, 32'h0005_0002, 32'hffff_ffff};
    logic [31:0] p;
    logic [31:0] q;
    wr(`TCAP_OFS_POST, 32'h0);
    for (int i = 0; i < 16; i++) begin
      p = i[0] ? mp[i >> 1] : hp[i >> 1];
      param_values[31:0] <= {~p[31:16], p[31:16]};
      wr(`TCAP_OFS_TDATA, {16'h0, p[15:0]});
      wr(`TCAP_OFS_CTRL, {28'h0, i[3:1], 1'b0});
      term_u.restart();
      cyc(30);
      rd(`TCAP_OFS_STATUS, q);
      chk("cond_state", {30'h0, q[1:0]}, i[0] ? 32'h1 : 32'h3);
    end
  endtask

  // Continuous capture rearms itself until a data read stops it.
  task automatic t_cont();
    logic [31:0] q;
    logic [31:0] s;
    param_values[15:0] <= 16'h0008;
    wr(`TCAP_OFS_CTRL, 32'h1);
    wr(`TCAP_OFS_TDATA, 32'h8);
    wr(`TCAP_OFS_POST, 32'd5);
    rd(`TCAP_OFS_ISTAT, q);
    term_u.restart();
    cyc(200);
    rd(`TCAP_OFS_STATUS, q);
    chk("ind_c", {24'h0, q[23:16]}, 32'h43);
    chk("running", {31'h0, q[1:0] != 2'h0}, 32'h1);
    chk("irq_cont", {31'h0, irq}, 32'h1);
    rd(`TCAP_OFS_RDATA, q);
    rd(`TCAP_OFS_STATUS, s);
    chk("stopped", {30'h0, s[1:0]}, 32'h0);
    cyc(40);
    rdchk("frozen", `TCAP_OFS_STATUS, s);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset for two cycles, then each scenario in turn.
  initial begin
    sys_clk      = 1'b0;
    rst_n        = 1'b0;
    param_values = 256'h0;
    errors       = 0;
    checks       = 0;
    cyc(2);
    rst_n <= 1'b1;
    cyc(1);
    t_reset_map();
    t_rate();
    t_single();
    t_cond();
    t_cont();
    finish_test();
  end

  // Watchdog well beyond the roughly 1800 cycles the scenarios need.
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    finish_test();
  end
endmodule // tcap_top_bench
`default_nettype wire
